// ===== pkg/exc_dispatch_pkg.sv
// constants for the exception dispatch check block
package exc_dispatch_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FLAGS = 8'h04;
  localparam logic [7:0] OFS_EVENT = 8'h08;
  localparam logic [7:0] OFS_SEL = 8'h0C;
  localparam logic [7:0] OFS_TASK = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_ERRCODE = 8'h18;
  localparam logic [7:0] OFS_SAVED = 8'h1C;
  localparam logic [7:0] OFS_LINK = 8'h20;
  // ctrl fields
  localparam int CTRL_CPL_LO = 0;
  localparam int CTRL_INTERRUPT_RETURN_INSTRUCTION = 8;
  // flag bit positions in the flags register and its saved image
  localparam int FLG_TRACE = 0;
  localparam int FLG_IE = 1;
  localparam int FLG_NEST = 2;
  localparam int FLG_RESUME = 3;
  localparam int FLG_V86 = 4;
  localparam logic [4:0] FLAGS_RST = 5'h00;
  // event fields
  localparam int EV_SRC_LO = 0;
  localparam int EV_GATE_LO = 4;
  localparam int EV_GDPL_LO = 8;
  localparam int EV_CDPL_LO = 10;
  localparam int EV_HAS_ERR = 12;
  localparam int EV_GATE32 = 13;
  localparam int EV_TSS_BUSY = 14;
  localparam int EV_SEG_REL = 15;
  localparam int EV_NULL_REF = 16;
  localparam int EV_LOCAL = 17;
  localparam int EV_IDT_REF = 18;
  localparam int EV_VEC_LO = 24;
  // status bits
  localparam int STS_DONE = 0;
  localparam int STS_BUSY = 1;
  localparam int STS_GP = 2;
  localparam int STS_TASK = 3;
  localparam int STS_ERRPUSH = 4;
  localparam int STS_ERR32 = 5;
  // event sources
  typedef enum logic [2:0] {
    SRC_SW_INT = 3'h0,
    SRC_BRKPT = 3'h1,
    SRC_OVFL = 3'h2,
    SRC_MASKABLE_PIN = 3'h3,
    SRC_LOCAL_PINS = 3'h4,
    SRC_CPU_EXC = 3'h5
  } src_t;
  // gate kinds
  typedef enum logic [1:0] {
    GATE_INT = 2'h0,
    GATE_TRAP = 2'h1,
    GATE_TASK = 2'h2
  } gate_t;
  // dispatch sequencer
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CHECK = 3'b001,
    ST_SAVE = 3'b010,
    ST_ENTER = 3'b011,
    ST_TASK = 3'b100
  } state_t;
endpackage : exc_dispatch_pkg

// ===== core/exc_dispatch.sv
// exception dispatch checks, flag handling, task dispatch and error code build
// Function
// - fault when handler code segment is less privileged than current level.
// - no requested-level check on implicit handler calls.
// - gate privilege checked only for vector call, breakpoint, overflow instructions.
// - software gate entry allowed only when current level <= gate level; the code skips this check for task gates.
// - hardware interrupts and cpu exceptions ignore gate privilege level.
// - interrupt or trap gate entry clears trace flag after flags saved.
// - handler entry clears v86, resume, nested flags after saving them.
// - interrupt return restores trace, v86, resume, nested from saved image.
// - interrupt gate entry clears interrupt-enable flag.
// - interrupt return restores interrupt-enable from saved image.
// - trap gate entry leaves interrupt-enable unchanged.
// - task gate vector performs a task switch, not a call.
// - task dispatch writes interrupted task link into handler task state.
// - task dispatch copies any error code to new task stack.
// - fault when dispatching to a handler task marked busy.
// - segment-related exceptions push an error code, procedure or task.
// - error bit 0 set when an outside event caused the exception.
// - error bit 1 set for interrupt table reference, clear otherwise.
// - error bit 2 selects local table, only meaningful with bit 1 clear.
// - null error code when not segment related or null descriptor.
// - error code word or doubleword by gate size, upper half zero, not popped.
// - no error code for pin-delivered events or vector call instruction.
//
// Implementation choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module exc_dispatch
  import exc_dispatch_pkg::*;
(
  input wire logic I_CLK_SYS, // 100 MHz core clock
  input wire logic I_NRST, // synchronous reset, active low
  input wire logic [7:0] I_ADDRESS, // avalon byte address
  input wire logic I_READ, // avalon read request
  input wire logic I_WRITE, // avalon write request
  input wire logic [31:0] I_WRITEDATA, // avalon write data
  input wire logic [3:0] I_BYTEENABLE, // avalon byte enables
  output logic [31:0] O_READDATA, // avalon read data
  output logic O_WAITREQUEST, // avalon wait request
  output logic O_GP_FAULT, // one-cycle pulse on protection fault
  output logic O_TASK_SWITCH, // one-cycle pulse on task dispatch
  output logic O_IE_FLAG // live interrupt-enable flag
);

  // merge write data into a register under byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : be_merge

  // build a selector-style error code; null wipes the whole lower word
  function automatic logic [31:0] err_fn(input logic outside_event_bit, input logic interrupt_descriptor_table, input logic loc,
                                         input logic [12:0] idx, input logic is_null);
    logic [31:0] res;
    res = 32'h0000_0000;
    if (!is_null) begin
      res[0] = outside_event_bit;
      res[1] = interrupt_descriptor_table;
      // local table select only without table bit
      res[2] = interrupt_descriptor_table ? 1'b0 : loc;
      res[15:3] = idx;
    end
    return res;
  endfunction : err_fn

  logic wait_r;
  logic [31:0] rdata_r;
  logic [1:0] cpl_r;
  logic [4:0] flags_r;
  logic [4:0] saved_r;
  logic [31:0] event_r;
  logic [12:0] sel_idx_r;
  logic [15:0] cur_task_r;
  logic [15:0] hdl_task_r;
  logic [15:0] link_r;
  logic [31:0] err_r;
  logic [5:0] status_r;
  logic gp_r;
  logic ts_r;
  state_t state_r;

  // bus handshake terms
  logic acc_take;
  logic wr_do;
  logic rd_take;
  logic wr_event;
  logic wr_interrupt_return_instruction;
  assign acc_take = (I_READ | I_WRITE) & wait_r;
  assign wr_do = I_WRITE & ~wait_r;
  assign rd_take = I_READ & wait_r;
  assign wr_event = wr_do & (I_ADDRESS == OFS_EVENT) & (state_r == ST_IDLE);
  assign wr_interrupt_return_instruction = wr_do & (I_ADDRESS == OFS_CTRL) & I_BYTEENABLE[1] & I_WRITEDATA[CTRL_INTERRUPT_RETURN_INSTRUCTION];

  // accepted writes aimed at each writable register
  logic hit_ctrl;
  logic hit_flags;
  logic hit_sel;
  logic hit_task;
  logic hit_saved;
  assign hit_ctrl = wr_do & (I_ADDRESS == OFS_CTRL);
  assign hit_flags = wr_do & (I_ADDRESS == OFS_FLAGS);
  assign hit_sel = wr_do & (I_ADDRESS == OFS_SEL);
  assign hit_task = wr_do & (I_ADDRESS == OFS_TASK);
  assign hit_saved = wr_do & (I_ADDRESS == OFS_SAVED);

  // byte-lane merges, one per register; narrow fields are sliced from these
  // nets because a function result cannot be part-selected directly
  logic [31:0] mrg_ctrl;
  logic [31:0] mrg_flags;
  logic [31:0] mrg_sel;
  logic [31:0] mrg_task;
  logic [31:0] mrg_saved;
  assign mrg_ctrl = be_merge({30'h0000_0000, cpl_r}, I_WRITEDATA, I_BYTEENABLE);
  assign mrg_flags = be_merge({27'h0000_000, flags_r}, I_WRITEDATA, I_BYTEENABLE);
  assign mrg_sel = be_merge({19'h0_0000, sel_idx_r}, I_WRITEDATA, I_BYTEENABLE);
  assign mrg_task = be_merge({hdl_task_r, cur_task_r}, I_WRITEDATA, I_BYTEENABLE);
  assign mrg_saved = be_merge({27'h0000_000, saved_r}, I_WRITEDATA, I_BYTEENABLE);

  // decoded event fields
  src_t ev_src;
  gate_t ev_gate;
  logic [1:0] ev_gdpl;
  logic [1:0] ev_cdpl;
  logic [7:0] ev_vec;
  logic ev_sw;
  logic ev_no_err;
  assign ev_src = src_t'(event_r[EV_SRC_LO +: 3]);
  assign ev_gate = gate_t'(event_r[EV_GATE_LO +: 2]);
  assign ev_gdpl = event_r[EV_GDPL_LO +: 2];
  assign ev_cdpl = event_r[EV_CDPL_LO +: 2];
  assign ev_vec = event_r[EV_VEC_LO +: 8];
  // only the three instruction sources count as software
  assign ev_sw = (ev_src == SRC_SW_INT) | (ev_src == SRC_BRKPT) | (ev_src == SRC_OVFL);
  // pin events and vector calls never carry a code
  assign ev_no_err = (ev_src == SRC_MASKABLE_PIN) | (ev_src == SRC_LOCAL_PINS)
                   | (ev_src == SRC_SW_INT);

  // protection checks; no requested-level input exists at all
  // no requested-level check
  logic is_task;
  logic flt_code;
  logic flt_gate;
  logic flt_busy;
  assign is_task = (ev_gate == GATE_TASK);
  // handler code must be at least as privileged as current level
  assign flt_code = ~is_task & (ev_cdpl > cpl_r);
  // software entry through an interrupt or trap gate needs current level <= gate level
  // hardware sources skip the gate level entirely
  assign flt_gate = ~is_task & ev_sw & (cpl_r > ev_gdpl);
  assign flt_busy = is_task & event_r[EV_TSS_BUSY];
  // any protection fault ends the dispatch in the check state
  logic flt_any;
  assign flt_any = flt_code | flt_gate | flt_busy;

  // protection fault code: gate faults name the vector in the interrupt table
  logic [31:0] gp_code;
  logic [31:0] ev_code;
  always_comb begin
    if (flt_gate) begin
      gp_code = err_fn(~ev_sw, 1'b1, 1'b0, {5'h00, ev_vec}, 1'b0);
    end else if (flt_code) begin
      gp_code = err_fn(~ev_sw, 1'b0, event_r[EV_LOCAL], sel_idx_r, 1'b0);
    end else begin
      gp_code = err_fn(~ev_sw, 1'b0, hdl_task_r[2], hdl_task_r[15:3], 1'b0);
    end
  end
  // null code when not segment related or null descriptor referenced
  assign ev_code = err_fn(~ev_sw, event_r[EV_IDT_REF], event_r[EV_LOCAL], sel_idx_r,
                          ~event_r[EV_SEG_REL] | event_r[EV_NULL_REF]);

  // avalon wait: one wait cycle per access, then release
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= ~acc_take;
    end
  end

  // read data latched as the access is taken, stable in the release cycle
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      rdata_r <= 32'h0000_0000;
    end else if (rd_take) begin
      case (I_ADDRESS)
        OFS_CTRL: rdata_r <= {30'h0000_0000, cpl_r};
        OFS_FLAGS: rdata_r <= {27'h0000_000, flags_r};
        OFS_EVENT: rdata_r <= event_r;
        OFS_SEL: rdata_r <= {19'h0_0000, sel_idx_r};
        OFS_TASK: rdata_r <= {hdl_task_r, cur_task_r};
        OFS_STATUS: rdata_r <= {26'h000_0000, status_r};
        OFS_ERRCODE: rdata_r <= err_r;
        OFS_SAVED: rdata_r <= {27'h0000_000, saved_r};
        OFS_LINK: rdata_r <= {16'h0000, link_r};
        default: rdata_r <= 32'h0000_0000; // unmapped reads as zero
      endcase
    end
  end

  // software-owned setup registers
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      cpl_r <= 2'h0;
      event_r <= 32'h0000_0000;
      sel_idx_r <= 13'h0000;
      hdl_task_r <= 16'h0000;
    end else begin
      if (hit_ctrl) begin
        cpl_r <= mrg_ctrl[1:0];
      end
      // event is frozen while a dispatch runs
      if (wr_event) begin
        event_r <= be_merge(event_r, I_WRITEDATA, I_BYTEENABLE);
      end
      if (hit_sel) begin
        sel_idx_r <= mrg_sel[12:0];
      end
      if (hit_task) begin
        hdl_task_r <= mrg_task[31:16];
      end
    end
  end

  // dispatch sequencer; saving and clearing sit in separate states
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (wr_event) begin
            state_r <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (flt_any) begin
            state_r <= ST_IDLE;
          // task gate goes to a switch, not a call
          end else if (is_task) begin
            state_r <= ST_TASK;
          end else begin
            state_r <= ST_SAVE;
          end
        end
        ST_SAVE: state_r <= ST_ENTER;
        ST_ENTER: state_r <= ST_IDLE;
        ST_TASK: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // stacked flags image: captured before any flag is cleared, software may edit it
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      saved_r <= FLAGS_RST;
    end else if (state_r == ST_SAVE) begin
      saved_r <= flags_r;
    end else if (hit_saved) begin
      saved_r <= mrg_saved[4:0];
    end
  end

  // live flags: entry clears win over a same-cycle software write
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      flags_r <= FLAGS_RST;
    end else if (state_r == ST_ENTER) begin
      // trace cleared only after save state
      flags_r[FLG_TRACE] <= 1'b0;
      // v86, resume, nested cleared after save
      flags_r[FLG_V86] <= 1'b0;
      flags_r[FLG_RESUME] <= 1'b0;
      flags_r[FLG_NEST] <= 1'b0;
      // trap gate keeps the enable as it was
      if (ev_gate == GATE_INT) begin
        flags_r[FLG_IE] <= 1'b0;
      end
    end else if (wr_interrupt_return_instruction) begin
      // return restores the five flags from the image
      flags_r[FLG_TRACE] <= saved_r[FLG_TRACE];
      flags_r[FLG_V86] <= saved_r[FLG_V86];
      flags_r[FLG_RESUME] <= saved_r[FLG_RESUME];
      flags_r[FLG_NEST] <= saved_r[FLG_NEST];
      flags_r[FLG_IE] <= saved_r[FLG_IE];
    end else if (hit_flags) begin
      flags_r <= mrg_flags[4:0];
    end
  end

  // task state: link back to interrupted task, handler becomes current
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      cur_task_r <= 16'h0000;
      link_r <= 16'h0000;
    end else if (state_r == ST_TASK) begin
      link_r <= cur_task_r;
      cur_task_r <= hdl_task_r;
    end else if (hit_task) begin
      cur_task_r <= mrg_task[15:0];
    end
  end

  // error code and status; a return leaves the code alone, it is never popped
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      err_r <= 32'h0000_0000;
      status_r <= 6'h00;
    end else if (wr_event) begin
      status_r <= 6'h02; // busy, previous outcome dropped
      err_r <= 32'h0000_0000;
    end else if (state_r == ST_CHECK) begin
      if (flt_any) begin
        // protection fault reported with its selector code
        status_r <= {event_r[EV_GATE32], 1'b1, 1'b0, 1'b1, 2'b01};
        err_r <= gp_code;
      end else if (event_r[EV_HAS_ERR] && !ev_no_err) begin
        // segment code pushed for procedure or task alike
        // task dispatch carries the same code to the new stack
        // size follows gate, upper half kept zero
        status_r[STS_ERRPUSH] <= 1'b1;
        status_r[STS_ERR32] <= event_r[EV_GATE32];
        err_r <= ev_code;
      end
    end else if (state_r == ST_TASK) begin
      status_r[STS_TASK] <= 1'b1;
      status_r[STS_BUSY] <= 1'b0;
      status_r[STS_DONE] <= 1'b1;
    end else if (state_r == ST_ENTER) begin
      status_r[STS_BUSY] <= 1'b0;
      status_r[STS_DONE] <= 1'b1;
    end
  end

  // outcome pulses for the surrounding core
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      gp_r <= 1'b0;
      ts_r <= 1'b0;
    end else begin
      gp_r <= (state_r == ST_CHECK) & flt_any;
      ts_r <= (state_r == ST_TASK);
    end
  end

  assign O_WAITREQUEST = wait_r;
  assign O_READDATA = rdata_r;
  assign O_GP_FAULT = gp_r;
  assign O_TASK_SWITCH = ts_r;
  assign O_IE_FLAG = flags_r[FLG_IE];

endmodule : exc_dispatch

// ===== testbench/sw_host.sv
// software-side bus master model driving the register port
`timescale 1ns/1ps
module sw_host (
  input wire logic i_clk, // core clock
  output logic [7:0] o_address, // byte address
  output logic o_read, // read request
  output logic o_write, // write request
  output logic [31:0] o_writedata, // write data
  output logic [3:0] o_byteenable, // lanes
  input wire logic [31:0] i_readdata, // read data
  input wire logic i_waitrequest // slave stall
);
  // idle bus from time zero
  initial begin
    o_address = 8'h00;
    o_read = 1'b0;
    o_write = 1'b0;
    o_writedata = 32'h0;
    o_byteenable = 4'hF;
  end
  // one access; starts a cycle late so read/write never get two updates in one step
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic to);
    int n;
    to = 1'b1;
    q = 32'h0;
    @(posedge i_clk);
    o_address <= a;
    o_writedata <= d;
    o_write <= we;
    o_read <= !we;
    for (n = 0; n < 20 && to; n++) begin
      @(posedge i_clk);
      if (i_waitrequest === 1'b0) begin
        q = i_readdata;
        to = 1'b0;
      end
    end
    o_read <= 1'b0;
    o_write <= 1'b0;
  endtask : xfer
endmodule : sw_host

// ===== testbench/exc_dispatch_checker.sv
// port assertions for the dispatch block
`timescale 1ns/1ps
module exc_dispatch_checker
  import exc_dispatch_pkg::*;
(
  input wire logic I_CLK_SYS, // clk
  input wire logic I_NRST, // rst
  input wire logic [7:0] I_ADDRESS, // addr
  input wire logic I_READ, // rd
  input wire logic I_WRITE, // wr
  input wire logic [31:0] I_WRITEDATA, // wdata
  input wire logic [3:0] I_BYTEENABLE, // be
  input wire logic [31:0] O_READDATA, // rdata
  input wire logic O_WAITREQUEST, // wait
  input wire logic O_GP_FAULT, // fault
  input wire logic O_TASK_SWITCH, // task
  input wire logic O_IE_FLAG // ie
);
  // accepted event writes whose handler code level is 0
  wire ev_w = I_WRITE && !O_WAITREQUEST && I_ADDRESS == OFS_EVENT && I_WRITEDATA[11:10] == 2'h0;
  wire ev_trap = ev_w && I_WRITEDATA[5:4] == GATE_TRAP;
  wire ev_int = ev_w && I_WRITEDATA[5:4] == GATE_INT && I_WRITEDATA[2:0] >= 3'h3;
  wire ev_task = ev_w && I_WRITEDATA[5:4] == GATE_TASK;
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_NRST);
  AST_WAIT_ONE: assert property ($fell(O_WAITREQUEST) |=> O_WAITREQUEST)
    else $error("wait low too long");
  AST_WAIT_TAKE: assert property ((I_READ || I_WRITE) && O_WAITREQUEST |=> !O_WAITREQUEST)
    else $error("request not taken");
  AST_GP_PULSE: assert property (O_GP_FAULT |=> !O_GP_FAULT)
    else $error("fault pulse too long");
  AST_IE_TRAP: assert property (ev_trap |=> $stable(O_IE_FLAG) [*4])
    else $error("trap gate moved ie");
  AST_IE_INT: assert property (ev_int |-> ##4 !O_IE_FLAG)
    else $error("int gate kept ie");
  AST_RD_UNMAPPED: assert property (I_READ && !O_WAITREQUEST && I_ADDRESS == 8'h24
    |-> O_READDATA == 32'h0)
    else $error("unmapped read not zero");
  AST_TASK_SW: assert property (ev_task && !I_WRITEDATA[EV_TSS_BUSY]
    |-> ##3 (O_TASK_SWITCH && !O_GP_FAULT))
    else $error("no task switch");
  AST_BUSY_GP: assert property (ev_task && I_WRITEDATA[EV_TSS_BUSY] |-> ##2 O_GP_FAULT)
    else $error("busy task not faulted");
  // main scenarios reached
  cover property (ev_trap);
  cover property (O_GP_FAULT);
  cover property (O_TASK_SWITCH);
endmodule : exc_dispatch_checker
bind exc_dispatch exc_dispatch_checker exc_dispatch_checker_inst (.I_CLK_SYS(I_CLK_SYS),
  .I_NRST(I_NRST), .I_ADDRESS(I_ADDRESS), .I_READ(I_READ), .I_WRITE(I_WRITE),
  .I_WRITEDATA(I_WRITEDATA), .I_BYTEENABLE(I_BYTEENABLE), .O_READDATA(O_READDATA),
  .O_WAITREQUEST(O_WAITREQUEST), .O_GP_FAULT(O_GP_FAULT), .O_TASK_SWITCH(O_TASK_SWITCH),
  .O_IE_FLAG(O_IE_FLAG));

// ===== testbench/testbench.sv
// self-checking bench for the dispatch block
`timescale 1ns/1ps
module testbench;
  import exc_dispatch_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] adr;
  logic rd, wr, wt, gp, tsw, ie;
  logic [31:0] wd, rdat, q;
  logic [3:0] be;
  int num_errors = 0;
  int n_compared = 0;
  int n_gp = 0;
  int n_ts = 0;
  // 100 MHz clock
  always #5 clk = ~clk;
  // outcome pulses counted as the surrounding core would see them
  always @(posedge clk) begin
    if (gp === 1'b1) begin
      n_gp <= n_gp + 1;
    end
    if (tsw === 1'b1) begin
      n_ts <= n_ts + 1;
    end
  end
  exc_dispatch exc_dispatch_inst (.I_CLK_SYS(clk), .I_NRST(nrst), .I_ADDRESS(adr), .I_READ(rd),
    .I_WRITE(wr), .I_WRITEDATA(wd), .I_BYTEENABLE(be), .O_READDATA(rdat), .O_WAITREQUEST(wt),
    .O_GP_FAULT(gp), .O_TASK_SWITCH(tsw), .O_IE_FLAG(ie));
  sw_host sw_host_inst (.i_clk(clk), .o_address(adr), .o_read(rd), .o_write(wr),
    .o_writedata(wd), .o_byteenable(be), .i_readdata(rdat), .i_waitrequest(wt));
  task automatic give_verdict();
    if (num_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict
  // a hung bus counts as a mismatch
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    logic to;
    sw_host_inst.xfer(we, a, d, q, to);
    if (to) begin
      num_errors++;
      give_verdict();
    end
  endtask : bus
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // event word, vector fixed at 21h
  function automatic logic [31:0] ev(input logic [2:0] s, input logic [1:0] g,
                                     input logic [1:0] gd, input logic [1:0] cd,
                                     input logic [6:0] b);
    return {8'h21, 5'h00, b, cd, gd, 2'h0, g, 1'h0, s};
  endfunction : ev
  // start an event and poll until done; q ends holding the status word
  task automatic dispatch(input logic [31:0] e);
    int n;
    bus(1'b1, OFS_EVENT, e);
    for (n = 0; n < 10; n++) begin
      bus(1'b0, OFS_STATUS, 32'h0);
      if (q[STS_DONE] === 1'b1 && q[STS_BUSY] === 1'b0) break;
    end
    if (n == 10) begin
      num_errors++;
      give_verdict();
    end
  endtask : dispatch
  task automatic t_int();
    bus(1'b0, 8'h24, 32'h0);
    chk("unmapped", 32'h0, q);
    bus(1'b1, OFS_CTRL, 32'h0);
    bus(1'b1, OFS_FLAGS, 32'h1F);
    dispatch(ev(SRC_CPU_EXC, GATE_INT, 2'h0, 2'h0, 7'h00));
    bus(1'b0, OFS_FLAGS, 32'h0);
    chk("flags int gate", 32'h0, q);
    bus(1'b0, OFS_SAVED, 32'h0);
    chk("saved image", 32'h1F, q);
    bus(1'b1, OFS_CTRL, 32'h100);
    bus(1'b0, OFS_FLAGS, 32'h0);
    chk("flags return", 32'h1F, q);
    chk("ie pin", 32'h1, {31'h0, ie});
  endtask : t_int
  task automatic t_trap();
    bus(1'b1, OFS_CTRL, 32'h3);
    bus(1'b1, OFS_FLAGS, 32'h1F);
    dispatch(ev(SRC_SW_INT, GATE_TRAP, 2'h3, 2'h0, 7'h00));
    bus(1'b0, OFS_FLAGS, 32'h0);
    chk("flags trap gate", 32'h02, q);
  endtask : t_trap
  task automatic t_gate_level();
    for (int s = 0; s < 6; s++) begin
      bus(1'b1, OFS_CTRL, 32'h2);
      dispatch(ev(s[2:0], GATE_INT, 2'h1, 2'h0, 7'h00));
      chk("gate fault", {31'h0, s < 3}, {31'h0, q[STS_GP]});
      if (s < 3) begin
        bus(1'b0, OFS_ERRCODE, 32'h0);
        chk("gate code", 32'h10A, q);
      end
    end
  endtask : t_gate_level
  task automatic t_code();
    int k;
    bus(1'b1, OFS_CTRL, 32'h0);
    bus(1'b1, OFS_SEL, 32'h55);
    k = n_gp;
    dispatch(ev(SRC_CPU_EXC, GATE_INT, 2'h0, 2'h2, 7'h20));
    chk("code fault pulse", k + 1, n_gp);
    bus(1'b0, OFS_ERRCODE, 32'h0);
    chk("code level fault", 32'h2AD, q);
  endtask : t_code
  task automatic t_task();
    int k;
    bus(1'b1, OFS_SEL, 32'h21);
    bus(1'b1, OFS_TASK, 32'h00480030);
    k = n_ts;
    dispatch(ev(SRC_CPU_EXC, GATE_TASK, 2'h0, 2'h0, 7'h69));
    chk("switch pulse", k + 1, n_ts);
    chk("task status", 32'h1, {31'h0, q[STS_TASK] & q[STS_ERRPUSH]});
    bus(1'b0, OFS_LINK, 32'h0);
    chk("link", 32'h30, {16'h0, q[15:0]});
    bus(1'b0, OFS_TASK, 32'h0);
    chk("task sel", 32'h00480048, q);
    bus(1'b1, OFS_CTRL, 32'h100);
    bus(1'b0, OFS_ERRCODE, 32'h0);
    chk("task code", 32'h10B, q);
  endtask : t_task
  task automatic t_busy();
    int k;
    bus(1'b1, OFS_TASK, 32'h004C0030);
    k = n_gp;
    dispatch(ev(SRC_MASKABLE_PIN, GATE_TASK, 2'h0, 2'h0, 7'h04));
    chk("busy fault pulse", k + 1, n_gp);
    chk("busy status", 32'h1, {31'h0, q[STS_GP] & ~q[STS_TASK]});
    bus(1'b0, OFS_ERRCODE, 32'h0);
    chk("busy code", 32'h4D, q);
  endtask : t_busy
  task automatic t_push();
    logic exp;
    for (int s = 0; s < 6; s++) begin
      exp = (s == 1 || s == 2 || s == 5);
      dispatch(ev(s[2:0], GATE_TRAP, 2'h3, 2'h0, 7'h1B));
      chk("pushed", {31'h0, exp}, {31'h0, q[STS_ERRPUSH]});
      if (exp) begin
        chk("dword", 32'h1, {31'h0, q[STS_ERR32]});
        bus(1'b0, OFS_ERRCODE, 32'h0);
        chk("null code", 32'h0, q);
      end
    end
  endtask : t_push
  // reset for five cycles, then scenarios
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_int();
    t_trap();
    t_gate_level();
    t_code();
    t_task();
    t_busy();
    t_push();
    give_verdict();
  end
endmodule : testbench
